// ---- core/ls_pkg.sv ----
// Constants for the local store and discrete register access block.
// Assumes one clock edge per microcycle phase; microword stable per microcycle.
package ls_pkg;
	localparam int MW_WIDTH     = 36;
	localparam int OP_HI        = 7;
	localparam int OP_LO        = 5;
	localparam int SRC_HI       = 25;
	localparam int SRC_LO       = 24;
	localparam int DIR_BIT      = 23;
	localparam int REGULAR_BIT  = 22;
	localparam int SEL_HI       = 21;
	localparam int SEL_LO       = 19;
	localparam int PAR_BYTE_BIT = 18;
	localparam int MUX_HI       = 18;
	localparam int MUX_LO       = 17;
	localparam int TX_HI        = 17;
	localparam int TX_LO        = 16;
	localparam int NIB_HI       = 19;
	localparam int NIB_LO       = 16;
	localparam int DIRECT_HI    = 23;
	localparam int DIRECT_LO    = 16;
	localparam int LIT_A_HI     = 18;
	localparam int LIT_A_LO     = 16;
	localparam int LIT_B_HI     = 11;
	localparam int LIT_B_LO     = 8;
	localparam int LIT_C_BIT    = 0;
	localparam int STORE_DEPTH  = 1024;
	localparam int STORE_AW     = 10;
	localparam int NIBBLE       = 4;
	localparam int TX_ENTRIES   = 4;
	localparam int TX_IW        = 2;
	localparam int SWITCH_IW    = 3;

	localparam logic [2:0] OP_TX_LOW   = 3'h2;
	localparam logic [2:0] OP_TX_HIGH  = 3'h3;
	localparam logic [2:0] OP_LS_WRITE = 3'h4;
	localparam logic [2:0] OP_DER      = 3'h5;

	localparam logic [1:0] SRC_SEGMENT = 2'h2;
	localparam logic [1:0] SRC_DIRECT  = 2'h3;

	localparam logic [2:0] RSEL_SLAVE_HI  = 3'h0;
	localparam logic [2:0] RSEL_SLAVE_LO  = 3'h1;
	localparam logic [2:0] RSEL_MASTER_HI = 3'h2;
	localparam logic [2:0] RSEL_MASTER_LO = 3'h3;
	localparam logic [2:0] RSEL_MUX       = 3'h4;
	localparam logic [2:0] RSEL_SLOW      = 3'h5;
	localparam logic [2:0] RSEL_PARALLEL  = 3'h6;
	localparam logic [2:0] RSEL_LITERAL   = 3'h7;

	localparam logic [1:0] MUX_SEL_SWITCH = 2'h0;

	typedef enum logic [1:0] {
		PH_T0   = 2'h0,
		PH_T50  = 2'h1,
		PH_T100 = 2'h3,
		PH_T150 = 2'h2
	} phase_t;
endpackage

// ---- core/store_ram.sv ----
// One nibble-wide slice of the local store.
// Assumes address and strobes come from flip-flops in the same clock domain.
`timescale 1ns/10ps
module store_ram #(
	parameter int WIDTH = 4,
	parameter int DEPTH = 1024,
	parameter int AW    = 10
) (
	input  wire logic             clk,
	input  wire logic             chip_select,
	input  wire logic             write_strobe,
	input  wire logic [AW-1:0]    address,
	input  wire logic [WIDTH-1:0] write_data,
	output logic      [WIDTH-1:0] read_data
);
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clk) begin
		if (chip_select && write_strobe) begin
			mem[address] <= write_data;
		end
	end

	// Output only while selected, as the tri-state device would
	always_comb begin
		read_data = '0;
		if (chip_select) begin
			read_data = mem[address];
		end
	end
endmodule

// ---- core/tx_data_ram.sv ----
// Transmit data RAM: low and high byte halves loaded from the local store.
// Assumes load strobes are one-cycle pulses from the access logic.
`timescale 1ns/10ps
module tx_data_ram #(
	parameter int ENTRIES = 4,
	parameter int IW      = 2
) (
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          low_load,
	input  wire logic          high_load,
	input  wire logic [IW-1:0] load_index,
	input  wire logic [7:0]    load_data,
	input  wire logic [IW-1:0] read_index,
	output logic      [15:0]   read_data
);
	logic [7:0]  low_mem  [ENTRIES];
	logic [7:0]  high_mem [ENTRIES];
	logic [15:0] next_read_data;

	always_comb begin
		next_read_data = {high_mem[read_index], low_mem[read_index]};
	end

	always_ff @(posedge clk) begin
		if (low_load) begin
			low_mem[load_index] <= load_data;
		end
		if (high_load) begin
			high_mem[load_index] <= load_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			read_data <= 16'h0000;
		end else begin
			read_data <= next_read_data;
		end
	end
endmodule

// ---- core/local_store_access.sv ----
// Local store access, address forming, transmit RAM loads and discrete reads.
// Assumes the sequencer changes the microword on the edge entering phase T0-50.
`timescale 1ns/10ps
module local_store_access (
	input  wire logic                          mclk,
	input  wire logic                          rstn,
	input  wire logic [ls_pkg::MW_WIDTH-1:0]   microword_register,
	input  wire logic [7:0]                    indirect_store_address,
	input  wire logic [ls_pkg::NIBBLE-1:0]     process_segment_register,
	input  wire logic [7:0]                    bus_in,
	input  wire logic [15:0]                   slave_rx_data,
	input  wire logic [15:0]                   master_rx_data,
	input  wire logic [7:0]                    slow_read_data,
	input  wire logic [15:0]                   parallel_receive_port,
	input  wire logic [7:0]                    status_in0,
	input  wire logic [7:0]                    status_in1,
	input  wire logic [7:0]                    status_in2,
	input  wire logic [7:0]                    status_in3,
	input  wire logic [7:0]                    address_switches,
	input  wire logic [ls_pkg::TX_IW-1:0]      tx_ram_read_index,
	output logic                               microcycle_start,
	output logic      [ls_pkg::STORE_AW-1:0]   store_address,
	output logic                               store_chip_select,
	output logic                               store_write_strobe,
	output logic      [7:0]                    bus_out,
	output logic                               bus_oe_n,
	output logic      [7:0]                    read_select,
	output logic                               status_mux_read_select,
	output logic                               literal_read_select,
	output logic                               discrete_access_select,
	output logic      [7:0]                    der_write_clk,
	output logic      [7:0]                    der_write_data,
	output logic                               slow_cycle_start,
	output logic                               slow_cycle_write,
	output logic                               tx_ram_low_load,
	output logic                               tx_ram_high_load,
	output logic      [15:0]                   tx_ram_read_data
);
	import ls_pkg::*;

	function automatic phase_t phase_after(input phase_t p);
		phase_t r;
		r = PH_T0;
		unique case (p)
			PH_T0:   r = PH_T50;
			PH_T50:  r = PH_T100;
			PH_T100: r = PH_T150;
			PH_T150: r = PH_T0;
		endcase
		return r;
	endfunction

	function automatic logic [7:0] one_hot(input logic [2:0] idx);
		logic [7:0] r;
		r = 8'h00;
		r[idx] = 1'b1;
		return r;
	endfunction

	logic        sync_ff1;
	logic        rst_n;
	phase_t      phase;
	phase_t      next_phase;
	logic [2:0]  op;
	logic [1:0]  src;
	logic [2:0]  sel;
	logic        ls_read_op;
	logic        ls_write_op;
	logic        der_op;
	logic        der_read;
	logic        der_write;
	logic        late;
	logic [7:0]  store_rdata;
	logic [7:0]  store_wdata;
	logic [7:0]  mux_value;
	logic [7:0]  status_hold;
	logic [7:0]  literal_value;
	logic [7:0]  read_source;

	logic                next_microcycle_start;
	logic [STORE_AW-1:0] next_store_address;
	logic                next_store_chip_select;
	logic                next_store_write_strobe;
	logic [7:0]          next_store_wdata;
	logic [7:0]          next_bus_out;
	logic                next_bus_oe_n;
	logic [7:0]          next_read_select;
	logic                next_discrete_access_select;
	logic [7:0]          next_der_write_clk;
	logic [7:0]          next_der_write_data;
	logic                next_slow_cycle_start;
	logic                next_slow_cycle_write;
	logic                next_tx_ram_low_load;
	logic                next_tx_ram_high_load;
	logic [7:0]          next_status_hold;

	// Reset release through two flops
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sync_ff1 <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			sync_ff1 <= 1'b1;
			rst_n    <= sync_ff1;
		end
	end

	assign op  = microword_register[OP_HI:OP_LO];
	assign src = microword_register[SRC_HI:SRC_LO];
	assign sel = microword_register[SEL_HI:SEL_LO];

	// Opcodes are exclusive, so a store read and write never share a cycle
	assign ls_write_op = (op == OP_LS_WRITE);
	assign ls_read_op  = !microword_register[OP_HI];
	assign der_op      = (op == OP_DER);
	assign der_read    = der_op && microword_register[REGULAR_BIT] && microword_register[DIR_BIT];
	assign der_write   = der_op && microword_register[REGULAR_BIT] && !microword_register[DIR_BIT];
	assign late        = (next_phase != PH_T0);

	// Two nibble slices accessed together form the byte-wide store
	for (genvar g = 0; g < 2; g++) begin : g_slice
		store_ram #(
			.WIDTH (NIBBLE),
			.DEPTH (STORE_DEPTH),
			.AW    (STORE_AW)
		) u_slice (
			.clk          (mclk),
			.chip_select  (store_chip_select),
			.write_strobe (store_write_strobe),
			.address      (store_address),
			.write_data   (store_wdata[g*NIBBLE +: NIBBLE]),
			.read_data    (store_rdata[g*NIBBLE +: NIBBLE])
		);
	end

	tx_data_ram #(
		.ENTRIES (TX_ENTRIES),
		.IW      (TX_IW)
	) u_tx_ram (
		.clk        (mclk),
		.rst_n      (rst_n),
		.low_load   (tx_ram_low_load),
		.high_load  (tx_ram_high_load),
		.load_index (microword_register[TX_HI:TX_LO]),
		.load_data  (store_rdata),
		.read_index (tx_ram_read_index),
		.read_data  (tx_ram_read_data)
	);

	// Status mux; group 0 bit 0 carries the indexed bus address switch
	always_comb begin
		mux_value = 8'h00;
		unique case (microword_register[MUX_HI:MUX_LO])
			MUX_SEL_SWITCH: mux_value = {status_in0[7:1],
				address_switches[indirect_store_address[SWITCH_IW-1:0]]};
			2'h1: mux_value = status_in1;
			2'h2: mux_value = status_in2;
			2'h3: mux_value = status_in3;
		endcase
	end

	assign literal_value = {microword_register[LIT_A_HI:LIT_A_LO],
		microword_register[LIT_B_HI:LIT_B_LO], microword_register[LIT_C_BIT]};

	// Regular read map; lower address bits give the byte within a group
	always_comb begin
		read_source = 8'h00;
		unique case (sel)
			RSEL_SLAVE_HI:  read_source = slave_rx_data[15:8];
			RSEL_SLAVE_LO:  read_source = slave_rx_data[7:0];
			RSEL_MASTER_HI: read_source = master_rx_data[15:8];
			RSEL_MASTER_LO: read_source = master_rx_data[7:0];
			RSEL_MUX:       read_source = status_hold;
			RSEL_SLOW:      read_source = slow_read_data;
			RSEL_PARALLEL:  read_source = microword_register[PAR_BYTE_BIT] ?
				parallel_receive_port[7:0] : parallel_receive_port[15:8];
			RSEL_LITERAL:   read_source = literal_value;
		endcase
	end

	always_comb begin
		next_phase                  = phase_after(phase);
		next_microcycle_start       = (phase_after(phase) == PH_T0);
		next_store_address          = {src, indirect_store_address};
		if (src == SRC_SEGMENT) begin
			next_store_address = {src, process_segment_register,
				microword_register[NIB_HI:NIB_LO]};
		end else if (src == SRC_DIRECT) begin
			next_store_address = {src, microword_register[DIRECT_HI:DIRECT_LO]};
		end
		next_store_chip_select      = (ls_read_op || ls_write_op) && late;
		next_store_write_strobe     = ls_write_op && (phase_after(phase) == PH_T100);
		next_store_wdata            = bus_in;
		// Read decode idles in T0-50 so the last driver releases first
		next_read_select            = der_read && late ? one_hot(sel) : 8'h00;
		next_bus_oe_n               = !((ls_read_op || der_read) && late);
		next_bus_out                = ls_read_op ? store_rdata : read_source;
		next_discrete_access_select = der_op;
		// Write clock edges land at T150; reads and writes share addresses
		next_der_write_clk          = (der_write && (phase_after(phase) == PH_T150)) ?
			one_hot(sel) : 8'h00;
		next_der_write_data         = bus_in;
		// Bit 22 low hands the access to the slow cycle, reads below 40h included
		next_slow_cycle_start       = der_op && !microword_register[REGULAR_BIT] &&
			(phase_after(phase) == PH_T50);
		next_slow_cycle_write       = !microword_register[DIR_BIT];
		next_tx_ram_low_load        = (op == OP_TX_LOW) && (phase_after(phase) == PH_T150);
		next_tx_ram_high_load       = (op == OP_TX_HIGH) && (phase_after(phase) == PH_T150);
		next_status_hold            = status_hold;
		if (phase == PH_T150) begin
			next_status_hold = mux_value;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			phase                  <= PH_T150;
			microcycle_start       <= 1'b0;
			store_address          <= '0;
			store_chip_select      <= 1'b0;
			store_write_strobe     <= 1'b0;
			store_wdata            <= 8'h00;
			bus_out                <= 8'h00;
			bus_oe_n               <= 1'b1;
			read_select            <= 8'h00;
			status_mux_read_select <= 1'b0;
			literal_read_select    <= 1'b0;
			discrete_access_select <= 1'b0;
			der_write_clk          <= 8'h00;
			der_write_data         <= 8'h00;
			slow_cycle_start       <= 1'b0;
			slow_cycle_write       <= 1'b0;
			tx_ram_low_load        <= 1'b0;
			tx_ram_high_load       <= 1'b0;
			status_hold            <= 8'h00;
		end else begin
			phase                  <= next_phase;
			microcycle_start       <= next_microcycle_start;
			store_address          <= next_store_address;
			store_chip_select      <= next_store_chip_select;
			store_write_strobe     <= next_store_write_strobe;
			store_wdata            <= next_store_wdata;
			bus_out                <= next_bus_out;
			bus_oe_n               <= next_bus_oe_n;
			read_select            <= next_read_select;
			status_mux_read_select <= next_read_select[RSEL_MUX];
			literal_read_select    <= next_read_select[RSEL_LITERAL];
			discrete_access_select <= next_discrete_access_select;
			der_write_clk          <= next_der_write_clk;
			der_write_data         <= next_der_write_data;
			slow_cycle_start       <= next_slow_cycle_start;
			slow_cycle_write       <= next_slow_cycle_write;
			tx_ram_low_load        <= next_tx_ram_low_load;
			tx_ram_high_load       <= next_tx_ram_high_load;
			status_hold            <= next_status_hold;
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	sequence full_microcycle;
		phase == PH_T0 ##1 phase == PH_T50 ##1 phase == PH_T100 ##1 phase == PH_T150;
	endsequence

	sequence write_walk;
		!store_write_strobe && store_chip_select ##1
		store_write_strobe && store_chip_select ##1
		!store_write_strobe && store_chip_select;
	endsequence

	phase_walk_a: assert property (microcycle_start |-> full_microcycle)
		else $error("microcycle phases out of order");

	store_write_walk_a: assert property (
		(phase == PH_T50 && $past(ls_write_op)) |-> write_walk)
		else $error("store write strobe not inside chip select window");

	write_by_op_a: assert property (store_write_strobe |-> op == OP_LS_WRITE)
		else $error("store written without write opcode");

	read_no_strobe_a: assert property (
		(ls_read_op && phase == PH_T100) |-> store_chip_select && !store_write_strobe && !bus_oe_n)
		else $error("store read did not drive the bus");

	select_idle_t0_a: assert property (
		phase == PH_T0 |-> read_select == 8'h00 && bus_oe_n)
		else $error("read select active in first phase");

	direct_address_a: assert property (
		(phase == PH_T100 && $stable(microword_register) && src == SRC_DIRECT)
		|-> store_address == {SRC_DIRECT, $past(microword_register[DIRECT_HI:DIRECT_LO])})
		else $error("direct store address wrong");

	segment_address_a: assert property (
		(phase == PH_T100 && $stable(microword_register) && $stable(process_segment_register)
		&& src == SRC_SEGMENT) |-> store_address[7:4] == process_segment_register)
		else $error("segment store address wrong");

	der_write_pulse_a: assert property (
		der_write_clk != 8'h00 |-> phase == PH_T150 && $onehot(der_write_clk)
		&& $past(der_write) ##1 der_write_clk == 8'h00)
		else $error("discrete write clock misplaced");

	tx_load_a: assert property (
		(tx_ram_low_load || tx_ram_high_load) |-> phase == PH_T150
		&& !(tx_ram_low_load && tx_ram_high_load))
		else $error("transmit RAM load misplaced");

	mux_hold_a: assert property (
		phase == PH_T150 |=> status_hold == $past(mux_value))
		else $error("status holding register not loaded at T150");

	quiet_cycle_a: assert property (
		!der_op |=> der_write_clk == 8'h00 && !slow_cycle_start)
		else $error("discrete cycle without discrete opcode");
endmodule

// ---- bench/sequencer_model.sv ----
// Sequencer and datapath model: one microword per microcycle.
// Assumes microcycle_start is high in phase T0 only.
`timescale 1ns/10ps
module sequencer_model (
	input  wire logic                        mclk,
	input  wire logic                        rstn,
	input  wire logic                        microcycle_start,
	input  wire logic                        cmd_valid,
	input  wire logic [ls_pkg::MW_WIDTH-1:0] cmd_word,
	input  wire logic [7:0]                  cmd_bus,
	input  wire logic [7:0]                  cmd_ind,
	input  wire logic [3:0]                  cmd_seg,
	output logic                             taken,
	output logic      [ls_pkg::MW_WIDTH-1:0] microword_register,
	output logic      [7:0]                  bus_in,
	output logic      [7:0]                  indirect_store_address,
	output logic      [3:0]                  process_segment_register
);
	import ls_pkg::*;
	logic [1:0] phase_count;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			phase_count <= 2'h0;
			taken <= 1'b0;
			microword_register <= 36'h0C0;
			bus_in <= 8'h00;
			indirect_store_address <= 8'h00;
			process_segment_register <= 4'h0;
		end else begin
			phase_count <= microcycle_start ? 2'h1 : phase_count + 2'h1;
			taken <= 1'b0;
			// New word only entering T0, back to back when queued
			if (phase_count == 2'h3) begin
				taken <= cmd_valid;
				microword_register <= cmd_valid ? cmd_word : 36'h0C0;
				bus_in <= cmd_valid ? cmd_bus : ~bus_in;
				indirect_store_address <= cmd_valid ? cmd_ind : indirect_store_address;
				process_segment_register <= cmd_valid ? cmd_seg : process_segment_register;
			end
		end
	end
endmodule

// ---- bench/local_store_access_test.sv ----
// Testbench for the local store access block with a sequencer model.
// Assumes the design holds its own local store and transmit RAM.
`timescale 1ns/10ps
module local_store_access_test;
	import ls_pkg::*;
	logic                mclk, rstn, cmd_valid, taken;
	logic [MW_WIDTH-1:0] microword_register, cmd_word, w;
	logic [7:0]          indirect_store_address, bus_in, cmd_bus, cmd_ind;
	logic [3:0]          process_segment_register, cmd_seg, rnd_seg;
	logic [15:0]         slave_rx_data, master_rx_data, parallel_receive_port, tx_ram_read_data;
	logic [7:0]          slow_read_data, status_in0, status_in1, status_in2, status_in3;
	logic [7:0]          address_switches, bus_out, read_select, der_write_clk, der_write_data;
	logic [1:0]          tx_ram_read_index;
	logic [9:0]          store_address;
	logic                microcycle_start, store_chip_select, store_write_strobe, bus_oe_n;
	logic                status_mux_read_select, literal_read_select, discrete_access_select;
	logic                slow_cycle_start, slow_cycle_write, tx_ram_low_load, tx_ram_high_load;
	logic [39:0]         exp_q[$];
	logic [7:0]          mem[int];
	logic [7:0]          tx_low[4], tx_high[4];
	logic [7:0]          mux_now, mux_next, rnd_ind;
	int                  num_errors, samples_checked, ph, seed;

	local_store_access uut (.mclk(mclk), .rstn(rstn), .microword_register(microword_register),
		.indirect_store_address(indirect_store_address),
		.process_segment_register(process_segment_register), .bus_in(bus_in),
		.slave_rx_data(slave_rx_data), .master_rx_data(master_rx_data),
		.slow_read_data(slow_read_data), .parallel_receive_port(parallel_receive_port),
		.status_in0(status_in0), .status_in1(status_in1), .status_in2(status_in2),
		.status_in3(status_in3), .address_switches(address_switches),
		.tx_ram_read_index(tx_ram_read_index), .microcycle_start(microcycle_start),
		.store_address(store_address), .store_chip_select(store_chip_select),
		.store_write_strobe(store_write_strobe), .bus_out(bus_out), .bus_oe_n(bus_oe_n),
		.read_select(read_select), .status_mux_read_select(status_mux_read_select),
		.literal_read_select(literal_read_select),
		.discrete_access_select(discrete_access_select), .der_write_clk(der_write_clk),
		.der_write_data(der_write_data), .slow_cycle_start(slow_cycle_start),
		.slow_cycle_write(slow_cycle_write), .tx_ram_low_load(tx_ram_low_load),
		.tx_ram_high_load(tx_ram_high_load), .tx_ram_read_data(tx_ram_read_data));

	sequencer_model seq (.mclk(mclk), .rstn(rstn), .microcycle_start(microcycle_start),
		.cmd_valid(cmd_valid), .cmd_word(cmd_word), .cmd_bus(cmd_bus), .cmd_ind(cmd_ind),
		.cmd_seg(cmd_seg), .taken(taken), .microword_register(microword_register),
		.bus_in(bus_in), .indirect_store_address(indirect_store_address),
		.process_segment_register(process_segment_register));

	initial mclk = 1'b0;
	always #10 mclk = ~mclk;

	task automatic check(input logic [39:0] seen, input logic [39:0] expected);
		samples_checked++;
		if (seen !== expected) begin
			num_errors++;
			$display("[ERR] %0t ns: saw %h, expected %h", $time, seen, expected);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	function automatic logic [39:0] pop_note();
		if (exp_q.size() == 0)
			return 40'h0;
		return exp_q.pop_front();
	endfunction

	function automatic logic [9:0] store_addr(input logic [35:0] v, input logic [7:0] ind,
		input logic [3:0] seg);
		case (v[SRC_HI:SRC_LO])
		SRC_SEGMENT: return {v[SRC_HI:SRC_LO], seg, v[NIB_HI:NIB_LO]};
		SRC_DIRECT: return {v[SRC_HI:SRC_LO], v[DIRECT_HI:DIRECT_LO]};
		default: return {v[SRC_HI:SRC_LO], ind};
		endcase
	endfunction

	function automatic logic [7:0] mux_value(input logic [1:0] g, input logic [7:0] ind);
		logic [7:0] v;
		v = (g == 2'h0) ? status_in0 : (g == 2'h1) ? status_in1 :
			(g == 2'h2) ? status_in2 : status_in3;
		if (g == MUX_SEL_SWITCH)
			v[0] = address_switches[ind[2:0]];
		return v;
	endfunction

	// Notes the expected outcome, then hands the word to the sequencer
	task automatic issue(input logic [35:0] v, input logic [7:0] b, input logic [7:0] ind,
		input logic [3:0] seg);
		logic [9:0] a;
		logic [2:0] sel;
		logic [7:0] d;
		a = store_addr(v, ind, seg);
		sel = v[SEL_HI:SEL_LO];
		mux_now = mux_next;
		mux_next = mux_value(v[MUX_HI:MUX_LO], ind);
		case (v[OP_HI:OP_LO])
		OP_LS_WRITE: begin
			exp_q.push_back({4'h2, 24'h0, 1'b0, 1'b1, a});
			mem[a] = b;
		end
		OP_DER: begin
			if (!v[REGULAR_BIT])
				exp_q.push_back({4'h5, 34'h0, 1'b1, !v[DIR_BIT]});
			else if (!v[DIR_BIT])
				exp_q.push_back({4'h3, 19'h0, 1'b1, 8'h01 << sel, b});
			else begin
				case (sel)
				RSEL_SLAVE_HI: d = slave_rx_data[15:8];
				RSEL_SLAVE_LO: d = slave_rx_data[7:0];
				RSEL_MASTER_HI: d = master_rx_data[15:8];
				RSEL_MASTER_LO: d = master_rx_data[7:0];
				RSEL_MUX: d = mux_now;
				RSEL_SLOW: d = slow_read_data;
				RSEL_PARALLEL: d = v[PAR_BYTE_BIT] ? parallel_receive_port[7:0] :
					parallel_receive_port[15:8];
				default: d = {v[LIT_A_HI:LIT_A_LO], v[LIT_B_HI:LIT_B_LO], v[LIT_C_BIT]};
				endcase
				exp_q.push_back({4'h1, 17'h0, 8'h01 << sel, sel == RSEL_MUX, sel == RSEL_LITERAL,
					1'b0, d});
			end
		end
		3'h6, 3'h7: ;
		default: begin
			d = mem[a];
			exp_q.push_back({4'h1, 17'h0, 8'h00, 3'h1, d});
			if (v[6])
				exp_q.push_back({4'h4, 34'h0, !v[5], v[5]});
			if (v[6] && v[5])
				tx_high[v[TX_HI:TX_LO]] = d;
			else if (v[6])
				tx_low[v[TX_HI:TX_LO]] = d;
		end
		endcase
		cmd_word <= v;
		cmd_bus <= b;
		cmd_ind <= ind;
		cmd_seg <= seg;
		cmd_valid <= 1'b1;
		@(posedge mclk);
		for (int n = 0; n < 8 && taken !== 1'b1; n++)
			@(posedge mclk);
	endtask

	task automatic settle(input string name);
		cmd_valid <= 1'b0;
		repeat (12) @(posedge mclk);
		$display("test %s done: %0d checks, %0d errors", name, samples_checked, num_errors);
	endtask

	function automatic logic [35:0] rand_word();
		return 36'({$urandom, $urandom});
	endfunction

	always @(negedge mclk) begin
		ph = microcycle_start ? 0 : ph + 1;
		if (microcycle_start)
			check(40'({store_chip_select, bus_oe_n, read_select}), 40'h100);
		if (ph != 2)
			check(40'(store_write_strobe), 40'h0);
		if (ph != 3)
			check(40'({der_write_clk, tx_ram_low_load, tx_ram_high_load}), 40'h0);
		if (ph == 1 && slow_cycle_start)
			check({4'h5, 34'h0, discrete_access_select, slow_cycle_write}, pop_note());
		if (ph == 2 && !bus_oe_n)
			check({4'h1, 17'h0, read_select, status_mux_read_select, literal_read_select,
				store_chip_select, bus_out}, pop_note());
		if (ph == 2 && store_write_strobe)
			check({4'h2, 24'h0, discrete_access_select, store_chip_select, store_address},
				pop_note());
		if (ph == 3 && der_write_clk != 8'h00)
			check({4'h3, 19'h0, discrete_access_select, der_write_clk, der_write_data},
				pop_note());
		if (ph == 3 && (tx_ram_low_load || tx_ram_high_load))
			check({4'h4, 34'h0, tx_ram_low_load, tx_ram_high_load}, pop_note());
	end

	initial begin
		repeat (5000) @(posedge mclk);
		num_errors++;
		$display("[ERR] %0t ns: watchdog expired", $time);
		print_verdict();
	end

	initial begin
		rstn = 1'b0;
		cmd_valid = 1'b0;
		cmd_word = '0;
		{cmd_bus, cmd_ind, cmd_seg, tx_ram_read_index} = '0;
		{slave_rx_data, master_rx_data, parallel_receive_port, slow_read_data} = '0;
		{status_in0, status_in1, status_in2, status_in3, address_switches} = '0;
		seed = $urandom(90);
		repeat (20) @(posedge mclk);
		check(40'({bus_oe_n, der_write_clk, store_chip_select, microcycle_start}), 40'h400);
		rstn <= 1'b1;
		slave_rx_data <= 16'($urandom);
		master_rx_data <= 16'($urandom);
		parallel_receive_port <= 16'($urandom);
		slow_read_data <= 8'($urandom);
		{status_in0, status_in1, status_in2, status_in3} <= $urandom;
		address_switches <= 8'($urandom);
		repeat (10) @(posedge mclk);
		for (int i = 0; i < 16; i++) begin
			w = rand_word();
			w[SRC_HI:SRC_LO] = i[1:0];
			w[TX_HI:TX_LO] = i[1:0];
			w[OP_HI:OP_LO] = OP_LS_WRITE;
			rnd_ind = 8'($urandom);
			rnd_seg = 4'($urandom);
			issue(w, 8'($urandom), rnd_ind, rnd_seg);
			w[OP_HI:OP_LO] = {2'b11, i[0]};
			issue(w, 8'($urandom), rnd_ind, rnd_seg);
			w[OP_HI:OP_LO] = {1'b0, i[3:2]};
			issue(w, 8'($urandom), rnd_ind, rnd_seg);
		end
		settle("store access");
		for (int i = 0; i < TX_ENTRIES; i++) begin
			tx_ram_read_index <= i[1:0];
			repeat (2) @(posedge mclk);
			check(40'(tx_ram_read_data), 40'({tx_high[i], tx_low[i]}));
		end
		for (int i = 0; i < 34; i++) begin
			w = rand_word();
			w[OP_HI:OP_LO] = OP_DER;
			w[REGULAR_BIT] = i < 32;
			w[DIR_BIT] = i[0];
			w[SEL_HI:SEL_LO] = i[3:1];
			w[PAR_BYTE_BIT] = i[4];
			issue(w, 8'($urandom), 8'($urandom), 4'($urandom));
		end
		for (int i = 0; i < 8; i++) begin
			w = rand_word();
			w[OP_HI:OP_LO] = 3'h6;
			w[MUX_HI:MUX_LO] = MUX_SEL_SWITCH;
			issue(w, 8'($urandom), 8'(i), 4'($urandom));
			w[OP_HI:OP_LO] = OP_DER;
			{w[DIR_BIT], w[REGULAR_BIT], w[SEL_HI:SEL_LO]} = {2'b11, RSEL_MUX};
			issue(w, 8'($urandom), 8'($urandom), 4'($urandom));
		end
		settle("discrete registers");
		check(40'(exp_q.size()), 40'h0);
		print_verdict();
	end
endmodule
